/* inc/pasmc_pkg.sv */
// Operation
// - Standby when code is coarse 02h or fine 04h/05h and power field 00b.
// - Standby stops switching and puts both output transistors in high-Z.
// - Power field 00b enters active; mode and voltage follow voltage code.
// - Coarse seven-bit code steps 30 mV; 0Dh to 78h is nominal range.
// - Fine eight-bit code steps 15 mV; 1Bh to F0h nominal, others accepted.
// - Switching-mode bit resets to 0 (PWM only); 1 selects auto PFM/PWM.
// - Bypass bit 1 forces bypass whatever the mode bit; 0 means auto bypass; the code has no auto bypass, and 0 gives active.
// - Auto mode uses PFM up to 60 mA and PWM above 120 mA.
// - Output low and steady limit over 10 us: high side off 30 us.
// - Shut down at 150C indication, resume only once below 125C.
// - Startup always in PWM; PFM only once load is at most 60 mA.
// - VIO resets registers asynchronously; low VIO means shutdown.
// - Drivers change data on clock rise; receivers sample on clock fall.
// - Slave answers broadcast ID 0000b as well as its unique ID.
// - Group ID defaults to 0000b.
// - Unique ID from strap at startup: low 0100b, high 0101b.
// - Unique ID reprogrammable by bus; value 0000b is ignored.
// - Pin control enable bit 1 drives strap pin with bit 7 level.
// - Low-power is default after VIO; also coarse 00h, fine 00h/01h, 10b; code also takes coarse 01h, fine 02h/03h.
// - Forced bypass also on coarse 7Fh or fine FEh/FFh.
// - Trigger-type writes wait for unmasked trigger; all masked is direct.
package pasmc_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_COARSE = 5'h00;
  localparam logic [4:0] ADDR_CONFIG = 5'h01;
  localparam logic [4:0] ADDR_FINE = 5'h03;
  localparam logic [4:0] ADDR_PINCTRL = 5'h06;
  localparam logic [4:0] ADDR_TRIGGER = 5'h1c;
  localparam logic [4:0] ADDR_SLAVEID = 5'h1f;
  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int BIT_MODE = 5;
  localparam int BIT_BYPASS = 4;
  localparam int BIT_PIN_LEVEL = 7;
  localparam int BIT_PIN_EN = 6;
  localparam logic [1:0] PS_NORMAL = 2'h0;
  localparam logic [1:0] PS_LOWPWR = 2'h2;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [6:0] COARSE_STANDBY = 7'h02;
  localparam logic [6:0] COARSE_BYPASS = 7'h7f;
  localparam logic [2:0] MASK_RESET = 3'h7;
  localparam logic [3:0] USID_STRAP_LOW = 4'h4;
  localparam logic [3:0] USID_STRAP_HIGH = 4'h5;
  localparam logic [3:0] SID_BROADCAST = 4'h0;
  localparam logic [3:0] GSID_RESET = 4'h0;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int LIMIT_TIME_NS = 10000;
  localparam int OFF_TIME_NS = 30000;
  localparam int LIMIT_CYCLES =
    (LIMIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OFF_CYCLES = OFF_TIME_NS / CLK_PERIOD_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam int SYNC_W = 9;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_SHUTDOWN = 3'h0,
    OP_LOWPWR = 3'h1,
    OP_STANDBY = 3'h3,
    OP_ACTIVE = 3'h2,
    OP_BYPASS = 3'h6
  } pasmc_op_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_DATA = 3'h3,
    ST_TAR = 3'h2,
    ST_READ = 3'h6
  } pasmc_st_type;
endpackage : pasmc_pkg

/* inc/pasmc_sync_if.sv */
`timescale 1ns/1ps
interface pasmc_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface : pasmc_sync_if

/* core/pasmc_sync.sv */
`timescale 1ns/1ps
module pasmc_sync #(parameter int W = 1) (
  input wire logic ref_clk,
  input wire logic rst,
  pasmc_sync_if.sync_side sif
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages per bit; only the second stage is ever read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= sif.raw;
      sync_q <= meta_q;
    end
  end

  assign sif.synced = sync_q;
endmodule : pasmc_sync

/* core/pasmc_top.sv */
`timescale 1ns/1ps
module pasmc_top import pasmc_pkg::*; (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vio_pin,
  input wire logic sclk,
  input wire logic sdata_in,
  output logic sdata_out,
  output logic sdata_oe_n,
  input wire logic strap_pin_in,
  output logic strap_pin_out,
  output logic strap_pin_oe_n,
  input wire logic vout_low,
  input wire logic steady_peak_limit,
  input wire logic load_light,
  input wire logic load_heavy,
  input wire logic temp_hot,
  input wire logic temp_cool,
  output logic [2:0] op_state,
  output logic switch_en,
  output logic stage_hiz,
  output logic forced_bypass,
  output logic pfm_mode,
  output logic hs_off,
  output logic [7:0] output_voltage_code
);
  // ----------------------------------------------------------------
  // Reset and input synchronisation
  // ----------------------------------------------------------------
  logic rst_int;
  assign rst_int = rst | ~vio_pin;

  pasmc_sync_if #(.W(SYNC_W)) sif ();
  assign sif.raw = {sclk, sdata_in, strap_pin_in, vout_low,
    steady_peak_limit, load_light, load_heavy, temp_hot, temp_cool};

  pasmc_sync #(.W(SYNC_W)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst_int),
    .sif(sif)
  );

  logic sclk_s, sdata_s, strap_s, vlow_s, ilim_s;
  logic light_s, heavy_s, hot_s, cool_s;
  assign {sclk_s, sdata_s, strap_s, vlow_s, ilim_s, light_s, heavy_s,
    hot_s, cool_s} = sif.synced;

  logic sclk_d_q, sdata_d_q;
  logic sclk_rise, sclk_fall, sdata_rise, sdata_fall;
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      sclk_d_q <= 1'b0;
      sdata_d_q <= 1'b0;
    end else begin
      sclk_d_q <= sclk_s;
      sdata_d_q <= sdata_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d_q;
  assign sclk_fall = ~sclk_s & sclk_d_q;
  assign sdata_rise = sdata_s & ~sdata_d_q & ~sclk_s;
  assign sdata_fall = ~sdata_s & sdata_d_q & ~sclk_s;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] code_q, pend_code_q;
  logic [1:0] cfg_q, pend_cfg_q;
  logic [1:0] ps_q;
  logic [2:0] mask_q;
  logic [1:0] pin_ctrl_q;
  logic [3:0] usid_q, gsid_q;
  logic [1:0] strap_cnt_q;
  logic strap_done_q;
  logic wr_stb_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic all_masked, trig_fire;

  assign all_masked = &mask_q;
  assign trig_fire = wr_stb_q && wr_addr_q == ADDR_TRIGGER &&
    |(wr_data_q[2:0] & ~wr_data_q[5:3]);

  function automatic logic [7:0] read_mux(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_COARSE: v = {1'b0, code_q[7:1]};
      ADDR_CONFIG: v = {2'h0, cfg_q, 4'h0};
      ADDR_FINE: v = code_q;
      ADDR_PINCTRL: v = {pin_ctrl_q, 6'h00};
      ADDR_TRIGGER: v = {ps_q, mask_q, 3'h0};
      ADDR_SLAVEID: v = {gsid_q, usid_q};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  pasmc_st_type st_q;
  logic [3:0] cnt_q;
  logic [11:0] sh_q;
  logic [7:0] cmd_q;
  logic [9:0] rd_sh_q;
  logic ssc_arm_q;
  logic sdata_out_q, sdata_oe_n_q;
  logic [12:0] frame;
  logic [8:0] dframe;
  logic hit;
  logic [7:0] rdata;

  assign frame = {sh_q, sdata_s};
  assign dframe = {sh_q[7:0], sdata_s};
  assign hit = frame[12:9] == usid_q || frame[12:9] == SID_BROADCAST ||
    frame[12:9] == gsid_q;
  assign rdata = read_mux(frame[5:1]);

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      ssc_arm_q <= 1'b0;
    end else if (sdata_rise) begin
      ssc_arm_q <= 1'b1;
    end else if (sclk_rise) begin
      ssc_arm_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 12'h000;
      cmd_q <= 8'h00;
      rd_sh_q <= 10'h000;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      if (sdata_fall && ssc_arm_q && st_q != ST_READ && st_q != ST_TAR)
      begin
        st_q <= ST_CMD;
        cnt_q <= 4'h0;
      end else if (sclk_fall) begin
        sh_q <= {sh_q[10:0], sdata_s};
        cnt_q <= cnt_q + 4'h1;
        case (st_q)
          ST_CMD: begin
            if (cnt_q == 4'hc) begin
              st_q <= ST_IDLE;
              cnt_q <= 4'h0;
              cmd_q <= frame[8:1];
              if (hit && ^frame) begin
                if (frame[8]) begin
                  wr_stb_q <= 1'b1;
                  wr_addr_q <= ADDR_COARSE;
                  wr_data_q <= {1'b0, frame[7:1]};
                end else if (frame[8:6] == 3'h2) begin
                  st_q <= ST_DATA;
                end else if (frame[8:6] == 3'h3 && frame[12:9] == usid_q)
                begin
                  st_q <= ST_TAR;
                  rd_sh_q <= {rdata, ~^rdata, 1'b0};
                end
              end
            end
          end
          ST_DATA: begin
            if (cnt_q == 4'h8) begin
              st_q <= ST_IDLE;
              if (^dframe) begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= cmd_q[4:0];
                wr_data_q <= dframe[8:1];
              end
            end
          end
          ST_TAR: begin
            st_q <= ST_READ;
            cnt_q <= 4'h0;
          end
          ST_READ: begin
            rd_sh_q <= {rd_sh_q[8:0], 1'b0};
            if (cnt_q == 4'h9) begin
              st_q <= ST_IDLE;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Slave drives only from the rise after bus park until the last park bit
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      sdata_out_q <= 1'b0;
      sdata_oe_n_q <= 1'b1;
    end else if (st_q == ST_READ && sclk_rise) begin
      sdata_out_q <= rd_sh_q[9];
      sdata_oe_n_q <= 1'b0;
    end else if (st_q != ST_READ) begin
      sdata_out_q <= 1'b0;
      sdata_oe_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger-type registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      pend_code_q <= CODE_RESET;
      pend_cfg_q <= 2'h0;
    end else if (wr_stb_q) begin
      case (wr_addr_q)
        ADDR_COARSE: pend_code_q <= {wr_data_q[6:0], 1'b0};
        ADDR_FINE: pend_code_q <= wr_data_q;
        ADDR_CONFIG: pend_cfg_q <= wr_data_q[BIT_MODE:BIT_BYPASS];
        default: pend_code_q <= pend_code_q;
      endcase
    end
  end

  // Active copies load at write time only when every trigger is masked
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      code_q <= CODE_RESET;
      cfg_q <= 2'h0;
    end else if (trig_fire) begin
      code_q <= pend_code_q;
      cfg_q <= pend_cfg_q;
    end else if (wr_stb_q && all_masked) begin
      case (wr_addr_q)
        ADDR_COARSE: code_q <= {wr_data_q[6:0], 1'b0};
        ADDR_FINE: code_q <= wr_data_q;
        ADDR_CONFIG: cfg_q <= wr_data_q[BIT_MODE:BIT_BYPASS];
        default: code_q <= code_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      ps_q <= PS_NORMAL;
      mask_q <= MASK_RESET;
    end else if (wr_stb_q && wr_addr_q == ADDR_TRIGGER) begin
      ps_q <= wr_data_q[7:6];
      mask_q <= wr_data_q[5:3];
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      pin_ctrl_q <= 2'h0;
    end else if (wr_stb_q && wr_addr_q == ADDR_PINCTRL) begin
      pin_ctrl_q <= wr_data_q[BIT_PIN_LEVEL:BIT_PIN_EN];
    end
  end

  // Strap is taken once the synchroniser has settled after reset
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      usid_q <= USID_STRAP_LOW;
      gsid_q <= GSID_RESET;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == STRAP_WAIT) begin
        strap_done_q <= 1'b1;
        usid_q <= strap_s ? USID_STRAP_HIGH : USID_STRAP_LOW;
      end
    end else if (wr_stb_q && wr_addr_q == ADDR_SLAVEID) begin
      gsid_q <= wr_data_q[7:4];
      if (wr_data_q[3:0] != SID_BROADCAST) begin
        usid_q <= wr_data_q[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power state and converter control
  // ----------------------------------------------------------------
  pasmc_op_type op_q, op_d;
  logic therm_q, pfm_q, hs_off_q;
  logic switch_en_q, stage_hiz_q, bypass_q;
  logic strap_out_q, strap_oe_n_q;
  logic [8:0] lim_cnt_q, off_cnt_q;

  always_comb begin
    op_d = op_q;
    if (ps_q == PS_LOWPWR || code_q[7:2] == 6'h00) begin
      op_d = OP_LOWPWR;
    end else if (ps_q == PS_NORMAL) begin
      if (code_q[7:1] == COARSE_STANDBY) begin
        op_d = OP_STANDBY;
      end else if (code_q[7:1] == COARSE_BYPASS || cfg_q[0]) begin
        op_d = OP_BYPASS;
      end else begin
        op_d = OP_ACTIVE;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      therm_q <= 1'b0;
    end else if (hot_s) begin
      therm_q <= 1'b1;
    end else if (cool_s) begin
      therm_q <= 1'b0;
    end
  end

  // Count a sustained limit, then hold the high side off
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      lim_cnt_q <= 9'h000;
      off_cnt_q <= 9'h000;
      hs_off_q <= 1'b0;
    end else if (hs_off_q) begin
      off_cnt_q <= off_cnt_q + 9'h001;
      if (off_cnt_q == 9'(OFF_CYCLES - 1)) begin
        hs_off_q <= 1'b0;
        lim_cnt_q <= 9'h000;
      end
    end else if (vlow_s && ilim_s) begin
      if (lim_cnt_q == 9'(LIMIT_CYCLES)) begin
        hs_off_q <= 1'b1;
        off_cnt_q <= 9'h000;
      end else begin
        lim_cnt_q <= lim_cnt_q + 9'h001;
      end
    end else begin
      lim_cnt_q <= 9'h000;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      op_q <= OP_SHUTDOWN;
      switch_en_q <= 1'b0;
      stage_hiz_q <= 1'b1;
      bypass_q <= 1'b0;
    end else begin
      op_q <= op_d;
      switch_en_q <= (op_d == OP_ACTIVE || op_d == OP_BYPASS) && !therm_q;
      stage_hiz_q <= op_d == OP_LOWPWR || op_d == OP_STANDBY || therm_q;
      bypass_q <= op_d == OP_BYPASS && !therm_q;
    end
  end

  // PFM is only ever entered from PWM, so every start begins in PWM
  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      pfm_q <= 1'b0;
    end else if (op_q != OP_ACTIVE || !cfg_q[1] || therm_q) begin
      pfm_q <= 1'b0;
    end else if (pfm_q) begin
      pfm_q <= !heavy_s;
    end else begin
      pfm_q <= light_s;
    end
  end

  always_ff @(posedge ref_clk or posedge rst_int) begin
    if (rst_int) begin
      strap_out_q <= 1'b0;
      strap_oe_n_q <= 1'b1;
    end else begin
      strap_out_q <= pin_ctrl_q[1];
      strap_oe_n_q <= !pin_ctrl_q[0];
    end
  end

  assign sdata_out = sdata_out_q;
  assign sdata_oe_n = sdata_oe_n_q;
  assign strap_pin_out = strap_out_q;
  assign strap_pin_oe_n = strap_oe_n_q;
  assign op_state = op_q;
  assign switch_en = switch_en_q;
  assign stage_hiz = stage_hiz_q;
  assign forced_bypass = bypass_q;
  assign pfm_mode = pfm_q;
  assign hs_off = hs_off_q;
  assign output_voltage_code = code_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst_int);

  property p_standby_hiz;
    op_q == OP_STANDBY && $past(op_q) == OP_STANDBY |->
      stage_hiz_q && !switch_en_q;
  endproperty
  a_standby_hiz: assert property (p_standby_hiz)
    else $error("standby with power stage live");

  property p_standby_entry;
    ps_q == PS_NORMAL && code_q[7:1] == COARSE_STANDBY |=>
      op_q == OP_STANDBY;
  endproperty
  a_standby_entry: assert property (p_standby_entry)
    else $error("standby code did not give standby");

  property p_bypass_forced;
    ps_q == PS_NORMAL && code_q[7:2] != 6'h00 &&
      code_q[7:1] != COARSE_STANDBY && cfg_q[0] |=> op_q == OP_BYPASS;
  endproperty
  a_bypass_forced: assert property (p_bypass_forced)
    else $error("bypass bit ignored");

  property p_pwm_start;
    $rose(op_q == OP_ACTIVE) |-> !pfm_q;
  endproperty
  a_pwm_start: assert property (p_pwm_start)
    else $error("active entered in pfm");

  property p_pwm_only;
    !cfg_q[1] |=> !pfm_q;
  endproperty
  a_pwm_only: assert property (p_pwm_only)
    else $error("pfm while pwm only selected");

  property p_hs_off_hold;
    $rose(hs_off_q) |-> hs_off_q [*8] ##0 off_cnt_q == 9'h007;
  endproperty
  a_hs_off_hold: assert property (p_hs_off_hold)
    else $error("high side off window cut short");

  property p_thermal;
    therm_q |=> !switch_en_q && stage_hiz_q;
  endproperty
  a_thermal: assert property (p_thermal)
    else $error("switching while over temperature");

  property p_usid_nonzero;
    strap_done_q |-> usid_q != SID_BROADCAST;
  endproperty
  a_usid_nonzero: assert property (p_usid_nonzero)
    else $error("unique id became broadcast");

  property p_gpo;
    pin_ctrl_q[0] |=> !strap_pin_oe_n &&
      strap_pin_out == $past(pin_ctrl_q[1]);
  endproperty
  a_gpo: assert property (p_gpo)
    else $error("strap pin not following control");

  property p_direct_write;
    wr_stb_q && all_masked && wr_addr_q == ADDR_FINE && !trig_fire |=>
      code_q == $past(wr_data_q);
  endproperty
  a_direct_write: assert property (p_direct_write)
    else $error("untriggered write not applied");

  property p_drive_on_rise;
    $changed(sdata_out_q) && !sdata_oe_n_q |-> $past(sclk_rise);
  endproperty
  a_drive_on_rise: assert property (p_drive_on_rise)
    else $error("data changed away from clock rise");
endmodule : pasmc_top

/* test/pasmc_master.sv */
`timescale 1ns/1ps
module pasmc_master (
  input wire logic ref_clk,
  input wire logic sdata_out,
  input wire logic sdata_oe_n,
  output logic sclk,
  output logic sdata_in
);
  logic sd;
  logic drv;
  logic last_q;
  // Nobody driving: show a level that keeps changing, never a stale bit
  assign sdata_in = !sdata_oe_n ? sdata_out : (drv ? sd : ~last_q);
  always_ff @(posedge ref_clk) begin
    last_q <= sdata_in;
  end
  initial begin
    sclk = 1'b0;
    sd = 1'b0;
    drv = 1'b1;
  end
  task half();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : half
  task put(input logic b);
    sclk = 1'b1;
    sd = b;
    half();
    sclk = 1'b0;
    half();
  endtask : put
  task xfer(input logic [3:0] sa, input logic [7:0] cmd,
      input logic [7:0] wd, input logic rd, output logic [7:0] q);
    logic [11:0] hd;
    logic [9:0] sh;
    hd = {sa, cmd};
    sh = 10'h000;
    sd = 1'b1;
    half();
    sd = 1'b0;
    half();
    for (int i = 11; i >= 0; i--) put(hd[i]);
    put(~^hd);
    if (!rd) begin
      // A coarse write carries its data in the command, with no data byte
      if (!cmd[7]) begin
        for (int i = 7; i >= 0; i--) put(wd[i]);
        put(~^wd);
      end
      put(1'b0);
    end else begin
      drv = 1'b0;
      put(1'b0);
      // Slave data stands rise to rise, so take it late in the low phase
      for (int i = 0; i < 10; i++) begin
        put(1'b0);
        sh = {sh[8:0], sdata_in};
      end
      drv = 1'b1;
    end
    q = sh[9:2];
  endtask : xfer
endmodule : pasmc_master

/* test/tb_pasmc_top.sv */
`timescale 1ns/1ps
module tb_pasmc_top import pasmc_pkg::*; ;
  logic ref_clk, rst, vio_pin, sclk, sdata_in, sdata_out, sdata_oe_n;
  logic strap_pin_in, strap_pin_out, strap_pin_oe_n, strap_ext;
  logic vout_low, steady_peak_limit, load_light, load_heavy;
  logic temp_hot, temp_cool, switch_en, stage_hiz, forced_bypass;
  logic pfm_mode, hs_off;
  logic [2:0] op_state;
  logic [7:0] output_voltage_code, q;
  int errors, compares, n;
  // Strap pin sees the outside level unless the block drives it
  assign strap_pin_in = strap_pin_oe_n ? strap_ext : strap_pin_out;
  pasmc_top pasmc_top_i (.ref_clk, .rst, .vio_pin, .sclk, .sdata_in,
    .sdata_out, .sdata_oe_n, .strap_pin_in, .strap_pin_out,
    .strap_pin_oe_n, .vout_low, .steady_peak_limit, .load_light,
    .load_heavy, .temp_hot, .temp_cool, .op_state, .switch_en,
    .stage_hiz, .forced_bypass, .pfm_mode, .hs_off,
    .output_voltage_code);
  pasmc_master pasmc_master_i (.ref_clk, .sdata_out, .sdata_oe_n,
    .sclk, .sdata_in);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task wt(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : wt
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task finish_test();
    $display("Compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task wr(input logic [3:0] sa, input logic [4:0] a, input logic [7:0] d);
    if (a == ADDR_COARSE)
      pasmc_master_i.xfer(sa, {1'b1, d[6:0]}, 8'h00, 1'b0, q);
    else
      pasmc_master_i.xfer(sa, {3'b010, a}, d, 1'b0, q);
    wt(6);
  endtask : wr
  task rd(input logic [3:0] sa, input logic [4:0] a);
    pasmc_master_i.xfer(sa, {3'b011, a}, 8'h00, 1'b1, q);
    wt(6);
    chk("sdata_oe_n", 8'h01, 8'(sdata_oe_n));
  endtask : rd
  task step(input logic [4:0] a, input logic [7:0] d,
      input pasmc_op_type e, input logic [7:0] c);
    logic on;
    on = (e == OP_ACTIVE) || (e == OP_BYPASS);
    wr(USID_STRAP_LOW, a, d);
    chk("op_state", 8'(e), 8'(op_state));
    chk("code", c, output_voltage_code);
    chk("switch_en", 8'(on), 8'(switch_en));
    chk("stage_hiz", 8'(!on), 8'(stage_hiz));
    chk("bypass", 8'(e == OP_BYPASS), 8'(forced_bypass));
  endtask : step
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset();
    chk("op_state", 8'(OP_LOWPWR), 8'(op_state));
    chk("stage_hiz", 8'h01, 8'(stage_hiz));
    rd(USID_STRAP_LOW, ADDR_SLAVEID);
    chk("ids", {GSID_RESET, USID_STRAP_LOW}, q);
    rd(USID_STRAP_LOW, ADDR_CONFIG);
    chk("config", 8'h00, q);
    rd(USID_STRAP_LOW, 5'h0a);
    chk("unmapped", 8'h00, q);
  endtask : t_reset
  task t_modes();
    step(ADDR_TRIGGER, 8'h38, OP_LOWPWR, 8'h00);
    step(ADDR_FINE, 8'h80, OP_ACTIVE, 8'h80);
    step(ADDR_FINE, 8'hf8, OP_ACTIVE, 8'hf8);
    step(ADDR_FINE, 8'h04, OP_STANDBY, 8'h04);
    step(ADDR_FINE, 8'h05, OP_STANDBY, 8'h05);
    step(ADDR_COARSE, 8'h02, OP_STANDBY, 8'h04);
    step(ADDR_COARSE, 8'h0d, OP_ACTIVE, 8'h1a);
    rd(USID_STRAP_LOW, ADDR_COARSE);
    chk("coarse", 8'h0d, q);
    step(ADDR_COARSE, 8'h7f, OP_BYPASS, 8'hfe);
    step(ADDR_FINE, 8'hff, OP_BYPASS, 8'hff);
    step(ADDR_FINE, 8'h01, OP_LOWPWR, 8'h01);
    step(ADDR_FINE, 8'h80, OP_ACTIVE, 8'h80);
    step(ADDR_TRIGGER, 8'hb8, OP_LOWPWR, 8'h80);
    step(ADDR_TRIGGER, 8'h38, OP_ACTIVE, 8'h80);
    step(ADDR_CONFIG, 8'h30, OP_BYPASS, 8'h80);
    step(ADDR_CONFIG, 8'h00, OP_ACTIVE, 8'h80);
    step(ADDR_TRIGGER, 8'h78, OP_ACTIVE, 8'h80);
    step(ADDR_FINE, 8'h04, OP_ACTIVE, 8'h04);
    step(ADDR_TRIGGER, 8'h38, OP_STANDBY, 8'h04);
    step(ADDR_FINE, 8'h80, OP_ACTIVE, 8'h80);
  endtask : t_modes
  task t_pfm();
    load_light = 1'b1;
    wt(10);
    chk("pfm_mode", 8'h00, 8'(pfm_mode));
    load_light = 1'b0;
    wr(USID_STRAP_LOW, ADDR_CONFIG, 8'h20);
    chk("pfm_mode", 8'h00, 8'(pfm_mode));
    load_light = 1'b1;
    wt(10);
    chk("pfm_mode", 8'h01, 8'(pfm_mode));
    load_light = 1'b0;
    wt(10);
    chk("pfm_mode", 8'h01, 8'(pfm_mode));
    load_heavy = 1'b1;
    wt(10);
    chk("pfm_mode", 8'h00, 8'(pfm_mode));
    load_heavy = 1'b0;
    wr(USID_STRAP_LOW, ADDR_CONFIG, 8'h00);
  endtask : t_pfm
  task t_limit();
    steady_peak_limit = 1'b1;
    wt(150);
    chk("hs_off", 8'h00, 8'(hs_off));
    vout_low = 1'b1;
    for (n = 0; hs_off !== 1'b1 && n < 200; n++) wt(1);
    chk("limit", 8'h01, 8'(n >= LIMIT_CYCLES && n <= LIMIT_CYCLES + 6));
    if (n == 200) finish_test();
    vout_low = 1'b0;
    for (n = 0; hs_off === 1'b1 && n < 400; n++) wt(1);
    chk("off", 8'h01, 8'(n >= OFF_CYCLES - 4 && n <= OFF_CYCLES + 4));
    if (n == 400) finish_test();
    steady_peak_limit = 1'b0;
  endtask : t_limit
  task t_thermal();
    temp_cool = 1'b0;
    temp_hot = 1'b1;
    wt(8);
    chk("switch_en", 8'h00, 8'(switch_en));
    chk("stage_hiz", 8'h01, 8'(stage_hiz));
    temp_hot = 1'b0;
    wt(8);
    chk("switch_en", 8'h00, 8'(switch_en));
    temp_cool = 1'b1;
    wt(8);
    chk("switch_en", 8'h01, 8'(switch_en));
  endtask : t_thermal
  task t_ids();
    wr(SID_BROADCAST, ADDR_FINE, 8'h84);
    chk("code", 8'h84, output_voltage_code);
    wr(4'h9, ADDR_FINE, 8'h90);
    chk("code", 8'h84, output_voltage_code);
    wr(USID_STRAP_LOW, ADDR_SLAVEID, 8'h00);
    rd(USID_STRAP_LOW, ADDR_SLAVEID);
    chk("ids", 8'h04, q);
    wr(USID_STRAP_LOW, ADDR_SLAVEID, 8'h36);
    rd(4'h6, ADDR_SLAVEID);
    chk("ids", 8'h36, q);
    wr(4'h3, ADDR_FINE, 8'h88);
    chk("code", 8'h88, output_voltage_code);
    wr(4'h6, ADDR_SLAVEID, 8'h04);
  endtask : t_ids
  task t_pin();
    wr(USID_STRAP_LOW, ADDR_PINCTRL, 8'hc0);
    chk("pin_oe_n", 8'h00, 8'(strap_pin_oe_n));
    chk("pin_out", 8'h01, 8'(strap_pin_out));
    wr(USID_STRAP_LOW, ADDR_PINCTRL, 8'h40);
    chk("pin_out", 8'h00, 8'(strap_pin_out));
    wr(USID_STRAP_LOW, ADDR_PINCTRL, 8'h80);
    chk("pin_oe_n", 8'h01, 8'(strap_pin_oe_n));
  endtask : t_pin
  task t_trig();
    wr(USID_STRAP_LOW, ADDR_TRIGGER, 8'h30);
    wr(USID_STRAP_LOW, ADDR_FINE, 8'h90);
    chk("code", 8'h88, output_voltage_code);
    wr(USID_STRAP_LOW, ADDR_TRIGGER, 8'h31);
    chk("code", 8'h90, output_voltage_code);
    wr(USID_STRAP_LOW, ADDR_TRIGGER, 8'h38);
  endtask : t_trig
  task t_vio();
    strap_ext = 1'b1;
    vio_pin = 1'b0;
    #20;
    chk("op_state", 8'(OP_SHUTDOWN), 8'(op_state));
    wt(3);
    vio_pin = 1'b1;
    wt(12);
    chk("op_state", 8'(OP_LOWPWR), 8'(op_state));
    chk("code", CODE_RESET, output_voltage_code);
    rd(USID_STRAP_HIGH, ADDR_SLAVEID);
    chk("ids", {GSID_RESET, USID_STRAP_HIGH}, q);
  endtask : t_vio
  initial begin
    rst = 1'b1;
    vio_pin = 1'b0;
    strap_ext = 1'b0;
    vout_low = 1'b0;
    steady_peak_limit = 1'b0;
    load_light = 1'b0;
    load_heavy = 1'b0;
    temp_hot = 1'b0;
    temp_cool = 1'b1;
    errors = 0;
    compares = 0;
    wt(16);
    rst = 1'b0;
    vio_pin = 1'b1;
    wt(10);
    t_reset();
    t_modes();
    t_pfm();
    t_limit();
    t_thermal();
    t_ids();
    t_pin();
    t_trig();
    t_vio();
    finish_test();
  end
endmodule : tb_pasmc_top
